// >>> bench/sdci_core_sva.sv
// assertion checker watching the ports of the sdram command interface
`timescale 1ns/1ns
module sdci_core_sva
   import sdci_pkg::*;
#(
   parameter int MEM_ROW_BITS = 2
) (
   input wire logic                      core_clk,
   input wire logic                      rst,
   input wire sdci_pkg::sdci_pins_t      pins,
   input wire logic [sdci_pkg::DQ_W-1:0] data_lines,
   input wire logic [sdci_pkg::DQ_W-1:0] data_lines_drive,
   input wire logic [sdci_pkg::DQ_W-1:0] data_lines_oe,
   input wire logic [sdci_pkg::BANKS-1:0] bank_open,
   input wire sdci_pkg::sdci_pwr_t       pwr_state,
   input wire logic                      burst_busy,
   input wire logic                      refresh_pulse,
   input wire logic                      read_latency3
);
   // ------------------------------------------------------------
   // helpers: enable level of the previous edge and decoded command
   // ------------------------------------------------------------
   logic cke_q_reg;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cke_q_reg <= 1'b0;
      end else begin
         cke_q_reg <= pins.cke;
      end
   end
   wire logic       live = cke_q_reg && !pins.cs_n;
   wire logic [2:0] op   = {pins.ras_n, pins.cas_n, pins.we_n};
   wire logic [1:0] bank = {pins.bank_sel_hi, pins.bank_sel_lo};
   wire logic       idle = (bank_open == 4'h0) && !burst_busy;
   wire logic       ref_go = live && op == 3'h1 && idle;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_act; live && op == 3'h3 && !bank_open[bank] |=> bank_open[$past(bank)]; endproperty
   a_act: assert property (p_act) else $error("activate did not open bank");
   property p_cs_ign; (cke_q_reg && pins.cs_n && !burst_busy)[*3] |=> $stable(bank_open); endproperty
   a_cs_ign: assert property (p_cs_ign) else $error("deselected command acted");
   property p_pre_all; live && op == 3'h2 && pins.addr[10] |=> bank_open == 4'h0; endproperty
   a_pre_all: assert property (p_pre_all) else $error("close all left a bank open");
   property p_pre_one; live && op == 3'h2 && !pins.addr[10] |=> !bank_open[$past(bank)]; endproperty
   a_pre_one: assert property (p_pre_one) else $error("single close failed");
   property p_ref; ref_go && pins.cke |=> refresh_pulse; endproperty
   a_ref: assert property (p_ref) else $error("refresh not pulsed");
   property p_ref_cause; refresh_pulse |-> $past(ref_go) && $past(pins.cke); endproperty
   a_ref_cause: assert property (p_ref_cause) else $error("stray refresh pulse");
   property p_self; ref_go && !pins.cke |=> pwr_state == PWR_SELF; endproperty
   a_self: assert property (p_self) else $error("self refresh not entered");
   // a no-operation at the falling enable edge behaves like deselect for power entry
   property p_down;
      cke_q_reg && !pins.cke && (pins.cs_n || op == 3'h7) && idle |=> pwr_state == PWR_DOWN;
   endproperty
   a_down: assert property (p_down) else $error("power down not entered");
   property p_susp;
      cke_q_reg && !pins.cke && (pins.cs_n || op == 3'h7) && (bank_open != 4'h0 || burst_busy)
         |=> pwr_state == PWR_SUSPEND;
   endproperty
   a_susp: assert property (p_susp) else $error("clock suspend not entered");
   property p_freeze;
      !cke_q_reg && !pins.cke |=> $stable(bank_open) && $stable(pwr_state) && $stable(data_lines_oe);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with clock gated");
   property p_wake; !cke_q_reg && pins.cke |=> pwr_state == PWR_RUN && $stable(bank_open);
   endproperty
   a_wake: assert property (p_wake) else $error("wake edge misbehaved");
   property p_mode;
      live && op == 3'h0 && idle && pins.cke && pins.addr[6:5] == 2'h1
         |=> read_latency3 == $past(pins.addr[4]);
   endproperty
   a_mode: assert property (p_mode) else $error("latency not programmed");
   // mask taken at edge e gates whatever beat leaves after edge e+2, if any
   property p_rd_mask;
      cke_q_reg && pins.cke && pins.low_byte_mask ##1 pins.cke |-> ##2 data_lines_oe[7:0] == 8'h00;
   endproperty
   a_rd_mask: assert property (p_rd_mask) else $error("masked lane driven");
endmodule : sdci_core_sva

// >>> bench/sdci_core_tb_top.sv
// self-checking testbench for the sdram command interface
`timescale 1ns/1ns
module sdci_core_tb_top;
   import sdci_pkg::*;
   localparam int ROWB = 1;
   localparam logic [2:0] C_MRS = 3'h0, C_REF = 3'h1, C_PRE = 3'h2, C_ACT = 3'h3;
   localparam logic [2:0] C_WR = 3'h4, C_RD = 3'h5, C_BST = 3'h6, C_NOP = 3'h7;
   logic             core_clk = 1'b0;
   logic             rst = 1'b1;
   sdci_pins_t       pins;
   logic [DQ_W-1:0]  data_lines, data_lines_drive, data_lines_oe;
   logic [BANKS-1:0] bank_open;
   sdci_pwr_t        pwr_state;
   logic             burst_busy, refresh_pulse, read_latency3;
   int               errors = 0;
   int               n_checks = 0;
   int               ref_seen = 0;
   int               seed_val;
   logic [31:0]      exp_q[$];  // {oe, masked drive} per read beat
   logic [15:0]      w[0:3];

   always #5 core_clk = ~core_clk;

   sdci_core #(.MEM_ROW_BITS(ROWB)) dut (.core_clk(core_clk), .rst(rst), .pins(pins),
      .data_lines(data_lines), .data_lines_drive(data_lines_drive),
      .data_lines_oe(data_lines_oe), .bank_open(bank_open), .pwr_state(pwr_state),
      .burst_busy(burst_busy), .refresh_pulse(refresh_pulse), .read_latency3(read_latency3));
   sdci_ctl_model ctl (.core_clk(core_clk), .pins(pins), .data_lines(data_lines));

   // ------------------------------------------------------------
   // comparison, bus helpers and closing
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cmd(input logic [2:0] op, input logic [1:0] bank, input logic [11:0] addr,
                      input logic [1:0] mask, input logic [15:0] wd);
      ctl.issue(1'b1, 1'b0, op, bank, addr, mask, op == C_WR, wd);
   endtask : cmd
   task automatic nop(input int n);
      repeat (n) ctl.issue(1'b1, 1'b0, C_NOP, 2'h0, 12'h000, 2'h0, 1'b0, 16'h0000);
   endtask : nop
   task automatic pw(input logic cke, input logic [2:0] op);
      ctl.issue(cke, 1'b0, op, 2'h0, 12'h000, 2'h0, 1'b0, 16'h0000);
   endtask : pw
   task automatic final_report();
      if (errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   // read beat watcher: every driven beat must match the oldest note
   always @(negedge core_clk) begin
      if (refresh_pulse === 1'b1) ref_seen++;
      if (!rst && data_lines_oe !== 16'h0000) begin
         if (exp_q.size() == 0) chk({data_lines_oe, 16'h0000}, 32'h0);
         else chk({data_lines_oe, data_lines_drive & data_lines_oe}, exp_q.pop_front());
      end
   end

   // watchdog sized well above the scripted sequence
   initial begin
      repeat (2000) @(posedge core_clk);
      errors++;
      final_report();
   end

   initial begin
      seed_val = $urandom(81);
      for (int i = 0; i < 4; i++) w[i] = 16'($urandom());
      repeat (6) @(posedge core_clk);
      @(negedge core_clk) rst = 1'b0;
      // length 1, latency 2; full write, then high lane blocked
      cmd(C_MRS, 2'h0, 12'h020, 2'h0, 16'h0);
      cmd(C_ACT, 2'h1, 12'h000, 2'h0, 16'h0);
      nop(1);
      chk(32'(bank_open), 32'h2);
      cmd(C_WR, 2'h1, 12'h005, 2'h0, w[0]);
      cmd(C_WR, 2'h1, 12'h006, 2'h0, w[1]);
      cmd(C_WR, 2'h1, 12'h006, 2'h2, w[2]);
      exp_q.push_back({16'hFF00, w[0] & 16'hFF00});
      // read mask must lead the latency-2 beat by one more edge than the command
      cmd(C_NOP, 2'h0, 12'h000, 2'h1, 16'h0);
      cmd(C_RD, 2'h1, 12'h005, 2'h0, 16'h0);
      exp_q.push_back({16'hFFFF, w[1][15:8], w[2][7:0]});
      cmd(C_RD, 2'h1, 12'h406, 2'h0, 16'h0);
      nop(4);
      chk(32'(bank_open), 32'h0);
      repeat (3) ctl.issue(1'b1, 1'b1, C_ACT, 2'h1, 12'h000, 2'h0, 1'b0, 16'h0);
      nop(1);
      chk(32'(bank_open), 32'h0);
      cmd(C_RD, 2'h1, 12'h005, 2'h0, 16'h0);  // closed bank, no beat expected
      for (int b = 0; b < 4; b++) cmd(C_ACT, 2'(b), 12'h001, 2'h0, 16'h0);
      nop(1);
      chk(32'(bank_open), 32'hF);
      cmd(C_PRE, 2'h2, 12'h000, 2'h0, 16'h0);
      nop(1);
      chk(32'(bank_open), 32'hB);
      cmd(C_PRE, 2'h0, 12'h400, 2'h0, 16'h0);
      nop(1);
      chk(32'(bank_open), 32'h0);
      // length 4 interleaved, latency 3: write from column 1, read from column 2
      cmd(C_MRS, 2'h0, 12'h03A, 2'h0, 16'h0);
      nop(1);
      chk(32'(read_latency3), 32'h1);
      cmd(C_ACT, 2'h0, 12'h001, 2'h0, 16'h0);
      cmd(C_WR, 2'h0, 12'h001, 2'h0, w[0]);
      for (int i = 1; i < 4; i++) ctl.issue(1'b1, 1'b0, C_NOP, 2'h0, 12'h0, 2'h0, 1'b1, w[i]);
      chk(32'(burst_busy), 32'h1);
      for (int i = 3; i >= 0; i--) exp_q.push_back({16'hFFFF, w[i]});
      cmd(C_RD, 2'h0, 12'h002, 2'h0, 16'h0);
      nop(8);
      // burst stop right after the read leaves a single beat
      exp_q.push_back({16'hFFFF, w[3]});
      cmd(C_RD, 2'h0, 12'h002, 2'h0, 16'h0);
      cmd(C_BST, 2'h0, 12'h000, 2'h0, 16'h0);
      nop(1);
      chk(32'(burst_busy), 32'h0);
      cmd(C_REF, 2'h0, 12'h000, 2'h0, 16'h0);  // refused, bank open
      nop(3);
      chk(32'(ref_seen), 32'h0);
      cmd(C_PRE, 2'h0, 12'h400, 2'h0, 16'h0);
      cmd(C_MRS, 2'h0, 12'h04A, 2'h0, 16'h0);
      nop(1);
      chk(32'(read_latency3), 32'h1);
      cmd(C_REF, 2'h0, 12'h000, 2'h0, 16'h0);
      nop(3);
      chk(32'(ref_seen), 32'h1);
      // power states: down, self refresh, suspend, ignored command on wake
      pw(1'b0, C_NOP);
      pw(1'b0, C_NOP);
      chk(32'(pwr_state), 32'(PWR_DOWN));
      pw(1'b1, C_NOP);
      nop(1);
      chk(32'(pwr_state), 32'(PWR_RUN));
      pw(1'b0, C_REF);
      pw(1'b0, C_NOP);
      chk(32'(pwr_state), 32'(PWR_SELF));
      pw(1'b1, C_NOP);
      cmd(C_ACT, 2'h0, 12'h000, 2'h0, 16'h0);
      pw(1'b0, C_NOP);
      pw(1'b0, C_NOP);
      chk(32'(pwr_state), 32'(PWR_SUSPEND));
      ctl.issue(1'b1, 1'b0, C_ACT, 2'h1, 12'h000, 2'h0, 1'b0, 16'h0);
      nop(1);
      chk(32'(bank_open), 32'h1);
      nop(2);
      chk(32'(exp_q.size()), 32'h0);
      final_report();
   end
endmodule : sdci_core_tb_top

bind sdci_core sdci_core_sva #(.MEM_ROW_BITS(MEM_ROW_BITS)) u_sva (.core_clk(core_clk),
   .rst(rst), .pins(pins), .data_lines(data_lines), .data_lines_drive(data_lines_drive),
   .data_lines_oe(data_lines_oe), .bank_open(bank_open), .pwr_state(pwr_state),
   .burst_busy(burst_busy), .refresh_pulse(refresh_pulse), .read_latency3(read_latency3));

// >>> bench/sdci_ctl_model.sv
// controller model driving command pins and write data at the falling edge
`timescale 1ns/1ns
module sdci_ctl_model
   import sdci_pkg::*;
(
   input  wire logic                  core_clk,
   output sdci_pkg::sdci_pins_t       pins,
   output logic [sdci_pkg::DQ_W-1:0]  data_lines
);
   int refresh_count;  // refresh budget over the interval is the controller's duty

   // idle pins at time zero: enable high, selected, no-operation
   initial begin
      pins = {1'b1, 1'b0, 3'h7, 2'h0, 12'h000, 2'h0};
      data_lines = 16'h0000;
      refresh_count = 0;
   end

   // one edge worth of pins; a released data bus shows the inverse, not the last word
   task automatic issue(input logic cke, input logic cs_n, input logic [2:0] op,
                        input logic [1:0] bank, input logic [11:0] addr,
                        input logic [1:0] mask, input logic wr, input logic [15:0] wd);
      @(negedge core_clk);
      pins = {cke, cs_n, op, bank, addr, mask};
      data_lines = wr ? wd : ~data_lines;
      if (op == 3'h1 && !cs_n) begin
         refresh_count++;
      end
   endtask : issue
endmodule : sdci_ctl_model

// >>> rtl/sdci_core.sv
// sdram command interface: bank state, bursts, masks, power states
`timescale 1ns/1ns
module sdci_core #(
   parameter int MEM_ROW_BITS = 2
) (
   input  wire logic                         core_clk,
   input  wire logic                         rst,
   input  wire sdci_pkg::sdci_pins_t         pins,
   input  wire logic [sdci_pkg::DQ_W-1:0]    data_lines,
   output logic      [sdci_pkg::DQ_W-1:0]    data_lines_drive,
   output logic      [sdci_pkg::DQ_W-1:0]    data_lines_oe,
   output logic      [sdci_pkg::BANKS-1:0]   bank_open,
   output sdci_pkg::sdci_pwr_t               pwr_state,
   output logic                              burst_busy,
   output logic                              refresh_pulse,
   output logic                              read_latency3
);
   import sdci_pkg::*;

   localparam int MEM_AW = BANK_W + MEM_ROW_BITS + COL_W;

   if (MEM_ROW_BITS < 1 || MEM_ROW_BITS > ROW_W || MASK_RD_LAT != 2) begin : g_bad_cfg
      $error("sdci_core: row bits must lie between 1 and the row width");
   end

   // ------------------------------------------------------------------
   // state record
   // ------------------------------------------------------------------
   typedef struct packed {
      sdci_pwr_t                      pwr;
      logic                           cke_prev;
      logic [BANKS-1:0]               open;
      logic [BANKS-1:0][ROW_W-1:0]    row;
      logic [2:0]                     bl;
      logic                           bt;
      logic                           cl3;
      logic                           wb_single;
      logic                           busy;
      logic                           wr;
      logic                           close;
      logic [BANK_W-1:0]              bank;
      logic [COL_W-1:0]               col;
      logic [COL_W-1:0]               idx;
      logic                           rd_v1;
      logic                           rd_v2;
      logic [DQ_W-1:0]                stage;
      logic [1:0]                     mask_d1;
      logic [1:0]                     mask_d2;
      logic [DQ_W-1:0]                dq_o;
      logic [DQ_W-1:0]                dq_oe;
      logic                           refresh_done;
   } sdci_core_state_t;

   localparam sdci_core_state_t STATE_RST = '{
      pwr: PWR_RUN, bl: RST_BL, bt: RST_BT, cl3: RST_CL3, wb_single: RST_WB,
      cke_prev: 1'b0, open: '0, row: '0, busy: 1'b0, wr: 1'b0, close: 1'b0,
      bank: '0, col: '0, idx: '0, rd_v1: 1'b0, rd_v2: 1'b0, stage: '0,
      mask_d1: '0, mask_d2: '0, dq_o: '0, dq_oe: '0, refresh_done: 1'b0};

   sdci_core_state_t  s_reg;
   sdci_core_state_t  s_next;
   sdci_cmd_t         cmd;
   logic [DQ_W-1:0]   mem_rdata;
   logic              mem_wr;
   logic              mem_rd;
   logic [1:0]        mem_be;
   logic [MEM_AW-1:0] mem_addr;

   // ------------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------------
   sdci_dec u_dec (
      .pins (pins),
      .cmd  (cmd)
   );

   sdci_mem #(
      .AW (MEM_AW),
      .DW (DQ_W)
   ) u_mem (
      .core_clk (core_clk),
      .rst      (rst),
      .wr_en    (mem_wr),
      .wr_be    (mem_be),
      .rd_en    (mem_rd),
      .addr     (mem_addr),
      .wr_data  (data_lines),
      .rd_data  (mem_rdata)
   );

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   // everything below is evaluated from pin levels present at the edge
   always_comb begin
      logic [BANK_W-1:0] sel;
      logic              idle;
      logic              acc;
      logic              acc_wr;
      logic [BANK_W-1:0] acc_bank;
      logic [COL_W-1:0]  acc_start;
      logic [COL_W-1:0]  acc_idx;
      logic [COL_W-1:0]  acc_col;
      logic              last;
      logic              ref_ok;
      s_next    = s_reg;
      sel       = {pins.bank_sel_hi, pins.bank_sel_lo};
      idle      = (s_reg.open == '0) && !s_reg.busy;
      acc       = 1'b0;
      acc_wr    = s_reg.wr;
      acc_bank  = s_reg.bank;
      acc_start = s_reg.col;
      acc_idx   = s_reg.idx;
      acc_col   = '0;
      last      = 1'b0;
      ref_ok    = 1'b0;
      mem_wr    = 1'b0;
      mem_rd    = 1'b0;
      mem_be    = 2'h0;
      mem_addr  = '0;
      s_next.cke_prev     = pins.cke;
      s_next.refresh_done = 1'b0;

      if (s_reg.cke_prev) begin
         // read return: memory word, optional extra stage, then the pins
         s_next.rd_v1   = 1'b0;
         s_next.rd_v2   = s_reg.rd_v1 && s_reg.cl3;
         s_next.stage   = mem_rdata;
         s_next.mask_d1 = {pins.high_byte_mask, pins.low_byte_mask};
         s_next.mask_d2 = s_reg.mask_d1;
         if (s_reg.rd_v2 || (s_reg.rd_v1 && !s_reg.cl3)) begin
            s_next.dq_o  = s_reg.rd_v2 ? s_reg.stage : mem_rdata;
            // mask seen two edges ago gates this beat's lanes
            s_next.dq_oe = {{8{~s_reg.mask_d2[1]}}, {8{~s_reg.mask_d2[0]}}};
         end else begin
            s_next.dq_oe = '0;
         end

         // a running burst takes one beat per enabled edge
         acc = s_reg.busy;

         case (cmd)
            CMD_ACT: begin
               if (!s_reg.open[sel]) begin
                  s_next.open[sel] = 1'b1;
                  s_next.row[sel]  = pins.addr;
               end
            end
            CMD_RD, CMD_WR: begin
               if (s_reg.open[sel]) begin
                  acc          = 1'b1;
                  acc_wr       = (cmd == CMD_WR);
                  acc_bank     = sel;
                  acc_start    = pins.addr[COL_W-1:0];
                  acc_idx      = '0;
                  s_next.wr    = acc_wr;
                  s_next.bank  = sel;
                  s_next.col   = acc_start;
                  s_next.close = pins.addr[AUTO_CLOSE_POS];
               end
            end
            CMD_PRE: begin
               if (pins.addr[AUTO_CLOSE_POS]) begin
                  s_next.open = '0;
               end else begin
                  s_next.open[sel] = 1'b0;
               end
               // a burst into a bank being closed is cut short
               if (pins.addr[AUTO_CLOSE_POS] || s_reg.bank == sel) begin
                  acc         = 1'b0;
                  s_next.busy = 1'b0;
               end
            end
            CMD_BST: begin
               acc         = 1'b0;
               s_next.busy = 1'b0;
            end
            CMD_MRS: begin
               if (idle) begin
                  s_next.wb_single = pins.addr[OP_WB_POS];
                  s_next.bt        = pins.addr[OP_BT_POS];
                  if (pins.addr[OP_CL_LSB +: 3] == CL_TWO ||
                      pins.addr[OP_CL_LSB +: 3] == CL_THREE) begin
                     s_next.cl3 = (pins.addr[OP_CL_LSB +: 3] == CL_THREE);
                  end
                  // reserved lengths and interleaved full page keep the old length
                  if (pins.addr[OP_BL_LSB +: 3] <= BL_MAX_CODE ||
                      (pins.addr[OP_BL_LSB +: 3] == BL_FULL && !pins.addr[OP_BT_POS])) begin
                     s_next.bl = pins.addr[OP_BL_LSB +: 3];
                  end
               end
            end
            CMD_REF: begin
               if (idle) begin
                  ref_ok = 1'b1;
                  if (pins.cke) begin
                     s_next.refresh_done = 1'b1;
                  end
               end
            end
            default: begin
               // deselect and no-operation leave the work in flight alone
            end
         endcase

         // one memory beat: address, write mask now, read into the pipe
         if (acc) begin
            acc_col  = burst_col(acc_start, acc_idx, s_next.bl, s_next.bt);
            mem_addr = {acc_bank, s_reg.row[acc_bank][MEM_ROW_BITS-1:0], acc_col};
            if (acc_wr) begin
               mem_wr = 1'b1;
               mem_be = ~{pins.high_byte_mask, pins.low_byte_mask};
            end else begin
               mem_rd       = 1'b1;
               s_next.rd_v1 = 1'b1;
            end
            last = burst_last(acc_idx, s_next.bl) || (acc_wr && s_next.wb_single);
            if (last) begin
               s_next.busy = 1'b0;
               if (s_next.close) begin
                  s_next.open[acc_bank] = 1'b0;
               end
            end else begin
               s_next.busy = 1'b1;
               s_next.idx  = acc_idx + 8'h01;
            end
         end

         // enable falling: the command above still ran, later edges freeze
         if (!pins.cke) begin
            if (ref_ok) begin
               s_next.pwr = PWR_SELF;
            end else if (s_next.busy || s_next.open != '0) begin
               s_next.pwr = PWR_SUSPEND;
            end else begin
               s_next.pwr = PWR_DOWN;
            end
         end
      end else begin
         // gated: nothing moves; enable rising leaves any low power state
         if (pins.cke) begin
            s_next.pwr = PWR_RUN;
         end
      end
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   // single edge capture point for every pin-derived value except the write data, byte enables and memory address, which u_mem takes itself
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_reg <= STATE_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------------
   // outputs, all straight from the state register
   // ------------------------------------------------------------------
   assign data_lines_drive = s_reg.dq_o;
   assign data_lines_oe    = s_reg.dq_oe;
   assign bank_open        = s_reg.open;
   assign pwr_state        = s_reg.pwr;
   assign burst_busy       = s_reg.busy;
   assign refresh_pulse    = s_reg.refresh_done;
   assign read_latency3    = s_reg.cl3;

endmodule : sdci_core

// >>> rtl/sdci_dec.sv
// command decoder for the sampled control pins
`timescale 1ns/1ns
module sdci_dec (
   input  wire sdci_pkg::sdci_pins_t pins,
   output sdci_pkg::sdci_cmd_t       cmd
);
   import sdci_pkg::*;

   // ------------------------------------------------------------------
   // strobe pattern to command
   // ------------------------------------------------------------------
   // chip select high blanks the decoder only; running work is untouched
   always_comb begin
      if (pins.cs_n) begin
         cmd = CMD_DESEL;
      end else begin
         case ({pins.ras_n, pins.cas_n, pins.we_n})
            3'b011:  cmd = CMD_ACT;
            3'b101:  cmd = CMD_RD;
            3'b100:  cmd = CMD_WR;
            3'b010:  cmd = CMD_PRE;
            3'b110:  cmd = CMD_BST;
            3'b000:  cmd = CMD_MRS;
            3'b001:  cmd = CMD_REF;
            default: cmd = CMD_NOP;
         endcase
      end
   end

endmodule : sdci_dec

// >>> rtl/sdci_mem.sv
// byte-writable storage array with registered read data
`timescale 1ns/1ns
module sdci_mem #(
   parameter int AW = 12,
   parameter int DW = 16
) (
   input  wire logic          core_clk,
   input  wire logic          rst,
   input  wire logic          wr_en,
   input  wire logic [1:0]    wr_be,
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wr_data,
   output logic      [DW-1:0] rd_data
);
   if (DW != 16 || AW < 1 || AW > 20) begin : g_bad_size
      $error("sdci_mem: unsupported width or depth");
   end

   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] rd_data_reg;

   // ------------------------------------------------------------------
   // array: contents are not reset, like the real cells
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (wr_en && wr_be[0]) begin
         mem[addr][7:0] <= wr_data[7:0];
      end
      if (wr_en && wr_be[1]) begin
         mem[addr][15:8] <= wr_data[15:8];
      end
   end

   // read port holds its word until the next read
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rd_data_reg <= 16'h0000;
      end else if (rd_en) begin
         rd_data_reg <= mem[addr];
      end
   end

   assign rd_data = rd_data_reg;

endmodule : sdci_mem

// >>> rtl/sdci_pkg.sv
// shared constants, types and helpers of the sdram command interface
package sdci_pkg;

   // ------------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------------
   localparam int ROW_W = 12;
   localparam int COL_W = 8;
   localparam int DQ_W  = 16;
   localparam int BANKS = 4;
   localparam int BANK_W = 2;
   localparam int AUTO_CLOSE_POS = 10;

   // ------------------------------------------------------------------
   // mode word field positions and codes
   // ------------------------------------------------------------------
   localparam int OP_BL_LSB = 0;
   localparam int OP_BT_POS = 3;
   localparam int OP_CL_LSB = 4;
   localparam int OP_WB_POS = 9;
   localparam logic [2:0] BL_MAX_CODE = 3'h3;
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam logic [2:0] CL_TWO = 3'h2;
   localparam logic [2:0] CL_THREE = 3'h3;

   // ------------------------------------------------------------------
   // latencies and reset values
   // ------------------------------------------------------------------
   localparam int MASK_RD_LAT = 2;
   localparam int MASK_WR_LAT = 0;
   localparam logic [2:0] RST_BL = 3'h0;
   localparam logic RST_BT = 1'b0;
   localparam logic RST_CL3 = 1'b0;
   localparam logic RST_WB = 1'b0;

   typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_SUSPEND, PWR_SELF} sdci_pwr_t;
   typedef enum logic [3:0] {CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
                             CMD_BST, CMD_MRS, CMD_REF} sdci_cmd_t;

   // command pins as seen by the device
   typedef struct packed {
      logic             cke;
      logic             cs_n;
      logic             ras_n;
      logic             cas_n;
      logic             we_n;
      logic             bank_sel_hi;
      logic             bank_sel_lo;
      logic [ROW_W-1:0] addr;
      logic             high_byte_mask;
      logic             low_byte_mask;
   } sdci_pins_t;

   // column of burst beat idx; sequential wraps inside the block, interleave xors
   function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                  input logic [COL_W-1:0] idx,
                                                  input logic [2:0] bl, input logic bt);
      logic [COL_W-1:0] msk;
      logic [COL_W-1:0] low;
      msk = (bl == BL_FULL) ? 8'hFF : (8'h01 << bl) - 8'h01;
      low = bt ? (start ^ idx) : (start + idx);
      return (start & ~msk) | (low & msk);
   endfunction : burst_col

   // true on the final beat; a full page burst never ends by itself
   function automatic logic burst_last(input logic [COL_W-1:0] idx, input logic [2:0] bl);
      return (bl != BL_FULL) && (idx == (8'h01 << bl) - 8'h01);
   endfunction : burst_last

endpackage : sdci_pkg
